// File: logic/eprom_read_program_control.sv
// eprom read/program control with axi4-lite register and array access
// Functional notes
// - vectors are sixteen bytes 7ff0 to 7fff
// - main array 0400 to 7dff, 31232 bytes
// - option byte decoded alone at 7fde
// - latch clear forces read mode, program off
// - reads with latch set return masked data
// - vectors invalid while latch is set
// - bootstrap rom blocked while latch set
// - stop entry returns eprom to read mode
// - erased byte reads as 00
// - repeated programming only accumulates ones
// - up to sixteen bytes share one group
// - program enable needs latch and a byte
// - stop and resets clear latch and program
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module eprom_read_program_control
  import eprom_pkg::*;
(
  input  wire logic        core_clk_i,          // core clock, 10 MHz
  input  wire logic        sys_rst_i,           // async reset, high
  input  wire logic        clk_en_i,            // freezes all state when low
  input  wire logic        stop_entry_i,        // pulse: core enters stop
  input  wire logic        eprom_supply_pin_i,  // programming supply present
  input  wire logic [17:0] s_axi_awaddr,        // write address
  input  wire logic        s_axi_awvalid,       // write address valid
  output logic             s_axi_awready,       // write address ready
  input  wire logic [31:0] s_axi_wdata,         // write data
  input  wire logic  [3:0] s_axi_wstrb,         // write lane strobes
  input  wire logic        s_axi_wvalid,        // write data valid
  output logic             s_axi_wready,        // write data ready
  output logic       [1:0] s_axi_bresp,         // write response
  output logic             s_axi_bvalid,        // write response valid
  input  wire logic        s_axi_bready,        // write response ready
  input  wire logic [17:0] s_axi_araddr,        // read address
  input  wire logic        s_axi_arvalid,       // read address valid
  output logic             s_axi_arready,       // read address ready
  output logic      [31:0] s_axi_rdata,         // read data
  output logic       [1:0] s_axi_rresp,         // read response
  output logic             s_axi_rvalid,        // read data valid
  input  wire logic        s_axi_rready,        // read data ready
  output logic             vector_valid_o,      // vector fetch may use eprom
  output logic             bootstrap_enable_o,  // bootstrap rom executable
  output logic             eprom_program_enable_o, // program enable state
  output logic       [7:0] eprom_option_byte_o  // option byte contents
);
  // ==========================================================
  // declarations
  localparam logic [15:0] opt_idx = `OPTION_IDX;
  localparam int          slots   = `GROUP_SLOTS;

  ctrl_type    ctrl;
  logic  [7:0] mem [0:`ARRAY_WORDS-1];
  logic        supply_meta;
  logic        supply_sync;
  logic        aw_held;
  logic        w_held;
  wr_req_type  wr;
  logic        do_write;
  region_type  wr_region;
  region_type  rd_region;
  logic        ctrl_wr;
  logic        eprom_wr;
  logic        group_hit;
  logic [10:0] group;
  logic [15:0] slot_load;
  logic [15:0] slot_valid;
  logic  [7:0] slot_data [0:slots-1];
  logic        any_valid;
  logic        prog_fire;
  logic  [7:0] rd_byte;

  // ==========================================================
  // address decode
  // the three eprom regions and the control byte; all else is unmapped
  function automatic region_type decode(input logic [15:0] idx);
    region_type r;
    r = region_none;
    if (idx == `CTRL_IDX) begin
      r = region_ctrl;
    end else if (idx >= `MAIN_FIRST && idx <= `MAIN_LAST) begin
      r = region_main;
    end else if (idx >= `VECT_FIRST && idx <= `VECT_LAST) begin
      r = region_vect;
    end else if (idx == `OPTION_IDX) begin
      r = region_opt;
    end
    return r;
  endfunction

  function automatic logic is_eprom(input region_type r);
    return (r == region_main) || (r == region_vect) || (r == region_opt);
  endfunction

  // ==========================================================
  // supply pin synchroniser; only the second stage is used
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      supply_meta <= 1'b0;
      supply_sync <= 1'b0;
    end else if (clk_en_i) begin
      supply_meta <= eprom_supply_pin_i;
      supply_sync <= supply_meta;
    end
  end

  // ==========================================================
  // write channel: address and data taken in either order
  assign s_axi_awready = clk_en_i && !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = clk_en_i && !w_held && !s_axi_bvalid;
  assign do_write      = clk_en_i && aw_held && w_held && !s_axi_bvalid;
  assign wr_region     = decode(wr.idx);

  // hold each half until both are present, then answer
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr           <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (clk_en_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr.idx  <= s_axi_awaddr[17:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wr.data <= s_axi_wdata[7:0];
        wr.strb <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_region == region_none) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // control register
  assign ctrl_wr   = do_write && wr.strb && (wr_region == region_ctrl);
  assign any_valid = |slot_valid;

  // stop entry outranks a simultaneous software write
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl <= `CTRL_RESET;
    end else if (clk_en_i) begin
      if (stop_entry_i) begin
        ctrl <= `CTRL_RESET;
      end else if (ctrl_wr) begin
        ctrl.lat <= wr.data[`CTRL_LAT_BIT];
        if (!wr.data[`CTRL_LAT_BIT]) begin
          ctrl.pgm <= 1'b0;
        end else if (wr.data[`CTRL_PGM_BIT] && ctrl.lat && any_valid) begin
          ctrl.pgm <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // group address and byte latches
  // a write outside the held group is dropped, the group stays put
  assign group_hit = !any_valid || (wr.idx[14:4] == group);
  assign eprom_wr  = do_write && wr.strb && is_eprom(wr_region) &&
                     ctrl.lat && !ctrl.pgm && group_hit;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      group <= 11'h000;
    end else if (clk_en_i && eprom_wr) begin
      group <= wr.idx[14:4];
    end
  end

  // one slot per low address nibble
  always_comb begin
    slot_load = 16'h0000;
    if (eprom_wr) begin
      slot_load[wr.idx[3:0]] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < slots; gi++) begin : g_slot
      eprom_latch_slot u_slot (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .clk_en_i   (clk_en_i),
        .clear_i    (!ctrl.lat),
        .load_i     (slot_load[gi]),
        .data_i     (wr.data),
        .valid_o    (slot_valid[gi]),
        .data_o     (slot_data[gi])
      );
    end
  endgenerate

  // ==========================================================
  // array; starts erased and only ever gains ones
  // the software sequence runs from ram and raises the supply after pgm
  assign prog_fire = ctrl.pgm && supply_sync;

  initial begin
    for (int i = 0; i < `ARRAY_WORDS; i++) begin
      mem[i] = `ERASED_BYTE;
    end
  end

  // or-ing keeps repeated passes cumulative, a one never returns to zero
  always @(posedge core_clk_i) begin
    if (clk_en_i && prog_fire) begin
      for (int s = 0; s < slots; s++) begin
        if (slot_valid[s]) begin
          mem[{group, s[3:0]}] <= mem[{group, s[3:0]}] | slot_data[s];
        end
      end
    end
  end

  // ==========================================================
  // read channel, one cycle from address to data
  assign s_axi_arready = clk_en_i && !s_axi_rvalid;
  assign rd_region     = decode(s_axi_araddr[17:2]);

  // array contents are hidden while the latch is set
  always_comb begin
    rd_byte = 8'h00;
    case (rd_region)
      region_ctrl: begin
        rd_byte[`CTRL_LAT_BIT] = ctrl.lat;
        rd_byte[`CTRL_PGM_BIT] = ctrl.pgm;
      end
      region_main, region_vect, region_opt: begin
        rd_byte = ctrl.lat ? `MASKED_BYTE : mem[s_axi_araddr[16:2]];
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (clk_en_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= (rd_region == region_none) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // status outputs toward the core
  assign vector_valid_o         = !ctrl.lat;
  assign bootstrap_enable_o     = !ctrl.lat;
  assign eprom_program_enable_o = ctrl.pgm;

  // option byte is an eprom byte; reset zeroes this copy, the first enabled clock reloads it as programmed
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      eprom_option_byte_o <= 8'h00;
    end else if (clk_en_i) begin
      eprom_option_byte_o <= mem[opt_idx[14:0]];
    end
  end

  // ==========================================================
  // checks
  logic  [14:0] watch_idx;
  logic   [7:0] watch_old;
  logic   [7:0] watch_add;
  logic  [10:0] group_q;

  // capture what slot zero should add so the array can be compared later
  always_ff @(posedge core_clk_i) begin
    watch_idx <= {group, 4'h0};
    watch_old <= mem[{group, 4'h0}];
    watch_add <= slot_data[0];
    group_q   <= group;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_ctrl_write(logic lat_v);
    ctrl_wr && !stop_entry_i && (wr.data[`CTRL_LAT_BIT] == lat_v);
  endsequence

  sequence s_arm_request;
    s_ctrl_write(1'b1) ##0 wr.data[`CTRL_PGM_BIT] && ctrl.lat && any_valid;
  endsequence

  a_pgm_needs_lat: assert property (ctrl.pgm |-> ctrl.lat)
    else $error("program enable set without latch enable");

  a_lat_clear_read: assert property (s_ctrl_write(1'b0) |=> !ctrl.lat && !ctrl.pgm)
    else $error("clearing latch did not return to read mode");

  a_pgm_arm_ok: assert property (s_arm_request |=> ctrl.pgm)
    else $error("program enable refused a legal arming write");

  a_pgm_no_slot: assert property (ctrl_wr && !any_valid && !ctrl.pgm |=> !ctrl.pgm)
    else $error("program enable set with empty latches");

  a_stop_to_read: assert property (clk_en_i && stop_entry_i |=> !ctrl.lat && !ctrl.pgm)
    else $error("stop entry did not clear latch and program");

  a_read_masked: assert property (s_axi_arvalid && s_axi_arready && ctrl.lat &&
    is_eprom(rd_region) |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
    else $error("array content visible while latch set");

  a_vector_gate: assert property (ctrl.lat |-> !vector_valid_o && !bootstrap_enable_o)
    else $error("vectors or bootstrap allowed with latch set");

  a_ones_accum: assert property (clk_en_i && prog_fire && slot_valid[0] |=>
    mem[watch_idx] == (watch_old | watch_add))
    else $error("programming did not or the latched byte");

  a_group_lock: assert property (clk_en_i && any_valid && ctrl.lat |=>
    group == group_q || !ctrl.lat)
    else $error("group address moved while latched");

  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[17:2] == 16'h7e00 |=> s_axi_rresp == `RESP_SLVERR)
    else $error("gap after main array answered as mapped");

  a_capture_slot: assert property (eprom_wr |=> slot_valid[$past(wr.idx[3:0])])
    else $error("eprom write with latch set not captured");

endmodule // eprom_read_program_control

// File: logic/eprom_params.svh
// constants for the eprom read and program control block
`ifndef EPROM_PARAMS_SVH
`define EPROM_PARAMS_SVH
// register indices; byte address on the bus is four times the index
`define CTRL_IDX      16'h0007
`define OPTION_IDX    16'h7fde
`define MAIN_FIRST    16'h0400
`define MAIN_LAST     16'h7dff
`define VECT_FIRST    16'h7ff0
`define VECT_LAST     16'h7fff
// control register field positions and values
`define CTRL_LAT_BIT  3'd5
`define CTRL_PGM_BIT  3'd4
`define CTRL_RESET    2'b00
`define ERASED_BYTE   8'h00
`define MASKED_BYTE   8'h00
// group latch shape and array size
`define GROUP_SLOTS   16
`define ARRAY_WORDS   32768
`define AXI_ADDR_W    18
// axi response codes
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`endif

// File: logic/eprom_pkg.sv
// types shared by the eprom read and program control block
`include "eprom_params.svh"
package eprom_pkg;
  // which part of the cpu map an access lands in
  typedef enum logic [2:0] {
    region_ctrl,
    region_main,
    region_vect,
    region_opt,
    region_none
  } region_type;
  // control bits kept by the block
  typedef struct packed {
    logic lat;
    logic pgm;
  } ctrl_type;
  // one captured write: cpu index, byte and lane strobe
  typedef struct packed {
    logic [15:0] idx;
    logic [7:0]  data;
    logic        strb;
  } wr_req_type;
endpackage

// File: logic/eprom_latch_slot.sv
// one data slot of the sixteen byte programming latch
`timescale 1ns/100ps
module eprom_latch_slot (
  input  wire logic       core_clk_i,  // core clock
  input  wire logic       sys_rst_i,   // async reset, high
  input  wire logic       clk_en_i,    // freezes state when low
  input  wire logic       clear_i,     // empties the slot
  input  wire logic       load_i,      // captures data_i
  input  wire logic [7:0] data_i,      // byte to hold
  output logic            valid_o,     // slot holds a byte
  output logic      [7:0] data_o       // held byte
);
  // ==========================================================
  // slot storage; clear wins so a dropped latch leaves nothing
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      valid_o <= 1'b0;
      data_o  <= 8'h00;
    end else if (clk_en_i) begin
      if (clear_i) begin
        valid_o <= 1'b0;
      end else if (load_i) begin
        valid_o <= 1'b1;
        data_o  <= data_i;
      end
    end
  end
endmodule // eprom_latch_slot

// File: test/eprom_supply_model.sv
// external programming supply switch model
`timescale 1ns/100ps
module eprom_supply_model (
  input  wire logic core_clk_i,   // core clock
  input  wire logic sys_rst_i,    // async reset, high
  input  wire logic request_i,    // routine asks for supply
  input  wire logic pgm_enable_i, // program enable pin
  output logic      supply_o      // switched supply
);
  // ======
  // switch
  // the routine toggles a port pin; the switch only closes once program
  // enable is up, so the array never sees supply in latch mode
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      supply_o <= 1'b0;
    end else begin
      supply_o <= request_i & pgm_enable_i;
    end
  end
endmodule // eprom_supply_model

// File: test/eprom_read_program_control_tb_top.sv
// self-checking bench for the eprom read and program control block
`timescale 1ns/100ps
`include "eprom_params.svh"
module eprom_read_program_control_tb_top import eprom_pkg::*;;
  logic        core_clk_i, sys_rst_i, clk_en_i, stop_entry_i, eprom_supply_pin_i;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic  [3:0] s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, supply_request;
  logic  [1:0] s_axi_bresp, s_axi_rresp;
  logic        vector_valid_o, bootstrap_enable_o, eprom_program_enable_o;
  logic  [7:0] eprom_option_byte_o;
  int          mismatches, n_compared;
  logic [15:0] map_idx [8] = '{16'h0400, 16'h7dff, 16'h7ff0, 16'h7fff,
                               16'h7fde, 16'h03ff, 16'h7e00, 16'h7fef};

  // ======
  // design and far side
  eprom_read_program_control eprom_read_program_control_inst (
    .core_clk_i, .sys_rst_i, .clk_en_i, .stop_entry_i, .eprom_supply_pin_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .vector_valid_o, .bootstrap_enable_o,
    .eprom_program_enable_o, .eprom_option_byte_o);
  eprom_supply_model eprom_supply_model_inst (
    .core_clk_i, .sys_rst_i, .request_i(supply_request),
    .pgm_enable_i(eprom_program_enable_o), .supply_o(eprom_supply_pin_i));

  // ======
  // compare and report
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ======
  // axi4-lite master; readies sampled at the falling edge, where they are settled
  task automatic wr(input logic [15:0] idx, input logic [7:0] data,
                    input logic [1:0] resp = `RESP_OKAY);
    logic aw_hs, w_hs, b_hs;
    int   t;
    t = 0;
    b_hs = 1'b0;
    @(posedge core_clk_i);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h000000, data};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_hs && t < 50) begin
      @(negedge core_clk_i);
      aw_hs = s_axi_awready;
      w_hs = s_axi_wready;
      b_hs = s_axi_bvalid;
      if (b_hs) check_data({30'h0, s_axi_bresp}, {30'h0, resp});
      @(posedge core_clk_i);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      t++;
    end
    s_axi_bready <= 1'b0;
    check_flag(b_hs, 1'b1);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] exp, input logic [1:0] resp);
    logic ar_hs, r_hs;
    int   t;
    t = 0;
    r_hs = 1'b0;
    @(posedge core_clk_i);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_hs && t < 50) begin
      @(negedge core_clk_i);
      ar_hs = s_axi_arready;
      r_hs = s_axi_rvalid;
      if (r_hs) begin
        check_data(s_axi_rdata, {24'h000000, exp});
        check_data({30'h0, s_axi_rresp}, {30'h0, resp});
      end
      @(posedge core_clk_i);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      t++;
    end
    s_axi_rready <= 1'b0;
    check_flag(r_hs, 1'b1);
  endtask
  // program the latched group; the hold stands in for the programming time
  task automatic burn();
    wr(`CTRL_IDX, 8'h30);
    check_flag(eprom_program_enable_o, 1'b1);
    supply_request <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    supply_request <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    wr(`CTRL_IDX, 8'h20);
    check_flag(eprom_program_enable_o, 1'b1);
    wr(`CTRL_IDX, 8'h00);
    check_flag(eprom_program_enable_o, 1'b0);
    check_flag(vector_valid_o, 1'b1);
  endtask

  // ======
  // clock and watchdog
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (5000) @(posedge core_clk_i);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end

  // ======
  // tests; the programming routine is modelled as running from ram
  initial begin
    {sys_rst_i, clk_en_i, s_axi_wstrb} = 6'h3f;
    {stop_entry_i, supply_request, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    s_axi_awaddr = 18'h00000;
    s_axi_araddr = 18'h00000;
    s_axi_wdata = 32'h00000000;
    repeat (16) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    check_flag(eprom_program_enable_o, 1'b0);
    rd(`CTRL_IDX, 8'h00, `RESP_OKAY);
    for (int i = 0; i < 8; i++) rd(map_idx[i], 8'h00, i < 5 ? `RESP_OKAY : `RESP_SLVERR);
    check_data({24'h0, eprom_option_byte_o}, 32'h0);
    end_test("map");
    wr(`CTRL_IDX, 8'h30);
    rd(`CTRL_IDX, 8'h20, `RESP_OKAY);
    wr(`CTRL_IDX, 8'h20);
    check_flag(vector_valid_o, 1'b0);
    check_flag(bootstrap_enable_o, 1'b0);
    wr(`CTRL_IDX, 8'h30);
    rd(`CTRL_IDX, 8'h20, `RESP_OKAY);
    wr(16'h0400, 8'h5a);
    wr(16'h040f, 8'h81);
    wr(16'h0410, 8'hff);
    rd(16'h0400, 8'h00, `RESP_OKAY);
    burn();
    rd(16'h0400, 8'h5a, `RESP_OKAY);
    rd(16'h040f, 8'h81, `RESP_OKAY);
    rd(16'h0410, 8'h00, `RESP_OKAY);
    end_test("group");
    wr(`CTRL_IDX, 8'h20);
    wr(16'h0400, 8'h24);
    burn();
    rd(16'h0400, 8'h7e, `RESP_OKAY);
    end_test("accumulate");
    wr(`CTRL_IDX, 8'h20);
    wr(16'h0401, 8'hff);
    wr(`CTRL_IDX, 8'h30);
    stop_entry_i <= 1'b1;
    @(posedge core_clk_i);
    stop_entry_i <= 1'b0;
    rd(`CTRL_IDX, 8'h00, `RESP_OKAY);
    check_flag(eprom_program_enable_o, 1'b0);
    check_flag(vector_valid_o, 1'b1);
    check_flag(bootstrap_enable_o, 1'b1);
    rd(16'h0401, 8'h00, `RESP_OKAY);
    end_test("stop");
    // option byte is burnt through the latch like any array byte
    wr(`CTRL_IDX, 8'h20);
    wr(16'h7fde, 8'ha5);
    burn();
    rd(16'h7fde, 8'ha5, `RESP_OKAY);
    check_data({24'h0, eprom_option_byte_o}, 32'h0000_00a5);
    wr(16'h7e00, 8'hff, `RESP_SLVERR);
    end_test("option");
    // a stop pulse while frozen is ignored, then a mid-run reset drops the latch
    wr(`CTRL_IDX, 8'h20);
    wr(16'h0402, 8'h11);
    wr(`CTRL_IDX, 8'h30);
    clk_en_i <= 1'b0;
    stop_entry_i <= 1'b1;
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    stop_entry_i <= 1'b0;
    @(posedge core_clk_i);
    check_flag(eprom_program_enable_o, 1'b1);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    check_flag(eprom_program_enable_o, 1'b0);
    check_flag(vector_valid_o, 1'b1);
    rd(`CTRL_IDX, 8'h00, `RESP_OKAY);
    rd(16'h0400, 8'h7e, `RESP_OKAY);
    rd(16'h0402, 8'h00, `RESP_OKAY);
    end_test("reset");
    finish_test();
  end
endmodule // eprom_read_program_control_tb_top
